//--- b4sram_defines.vh
// constants for the burst-of-four common-io sram port
`ifndef B4SRAM_DEFINES_VH
`define B4SRAM_DEFINES_VH
`define B4S_DATA_W 36
`define B4S_LANES 4
`define B4S_LANE_W 9
`define B4S_ADDR_W 8
`define B4S_WORDS 1024
`define B4S_BURST 4
`define B4S_DLL_LOCK_CYC 1024
`define B4S_BUF_DEPTH 2
`endif

//--- b4sram_core.v
// burst-of-four common-io sram device model, link side and array
`include "b4sram_defines.vh"

// Behaviour
// - read starts when select sampled high
// - all transfers are bursts of four
// - separate output clocks time read data
// - free-running echo clock aligned with data
// - single-clock mode uses input clock edges
// - address registered when load low
// - nop never aborts running read burst
// - drivers off when no read data
// - write starts when select sampled low
// - write words arrive one cycle later, ddr
// - buffered writes commit on third write
// - reads of recent writes return buffer data
// - active-low byte enables per lane per word
// - select high performs no write
// - loop disabled while disable input low
// - low two bits are burst start position
// - two-bit counter steps linear order
// - output clock edges launch words alternately
module b4s_core (
    // system
    input wire clk,
    input wire reset,
    // link clocks, sampled as plain inputs
    input wire in_clk,
    input wire out_clk,
    input wire out_clk_n,
    // control and address
    input wire read_write_sel,
    input wire address_load_n,
    input wire [`B4S_ADDR_W-1:0] array_address,
    input wire burst_start_bit_low,
    input wire burst_start_bit_high,
    input wire [`B4S_LANES-1:0] byte_write_enable_n,
    input wire dll_enable_n_low,
    // shared data bus, split
    input wire [`B4S_DATA_W-1:0] dq_in,
    output reg [`B4S_DATA_W-1:0] dq_out,
    output reg dq_oe,
    // echo clocks
    output reg echo_clock,
    output reg echo_clock_n,
    // status
    output reg dll_active,
    output reg dll_locked
);

// ----------------------------------------------------------------
// synchronisers and edge detection
// ----------------------------------------------------------------
reg [2:0] k_sync_r;
reg [2:0] c_sync_r;
reg [2:0] cn_sync_r;
reg [1:0] ctl_s1_r;
reg [1:0] ctl_s2_r;
reg [`B4S_ADDR_W+1:0] adr_s1_r;
reg [`B4S_ADDR_W+1:0] adr_s2_r;
reg [`B4S_LANES-1:0] bw_s1_r;
reg [`B4S_LANES-1:0] bw_s2_r;
reg [`B4S_DATA_W-1:0] d_s1_r;
reg [`B4S_DATA_W-1:0] d_s2_r;
reg [1:0] doff_s_r;
// slow link lets two stages settle well before each edge is seen
always @(posedge clk) begin
    k_sync_r <= {k_sync_r[1:0], in_clk};
    c_sync_r <= {c_sync_r[1:0], out_clk};
    cn_sync_r <= {cn_sync_r[1:0], out_clk_n};
    ctl_s1_r <= {read_write_sel, address_load_n};
    ctl_s2_r <= ctl_s1_r;
    adr_s1_r <= {array_address, burst_start_bit_high, burst_start_bit_low};
    adr_s2_r <= adr_s1_r;
    bw_s1_r <= byte_write_enable_n;
    bw_s2_r <= bw_s1_r;
    d_s1_r <= dq_in;
    d_s2_r <= d_s1_r;
    doff_s_r <= {doff_s_r[0], dll_enable_n_low};
end

wire k_rise = k_sync_r[1] & ~k_sync_r[2];
wire k_fall = ~k_sync_r[1] & k_sync_r[2];
// output clocks both held high means single-clock mode
wire single_clk = c_sync_r[1] & cn_sync_r[1];
wire c_rise = c_sync_r[1] & ~c_sync_r[2];
wire cn_rise = cn_sync_r[1] & ~cn_sync_r[2];
// launch edges for read words
wire t_edge = single_clk ? k_rise : c_rise;
wire n_edge = single_clk ? k_fall : cn_rise;

// ----------------------------------------------------------------
// command decode and burst address
// ----------------------------------------------------------------
function [1:0] b4s_pos;
    input [1:0] start;
    input [1:0] step;
    begin
        b4s_pos = start + step;
    end
endfunction

reg [`B4S_ADDR_W+1:0] addr_r;
reg phase_r; // second cycle of a burst, no new command
reg rd_pend_r;
reg [`B4S_ADDR_W-1:0] rd_row_r;
reg [1:0] rd_start_r;
reg wr_pend_r;
reg [`B4S_ADDR_W-1:0] wr_row_r;
reg [1:0] wr_start_r;
wire [`B4S_ADDR_W+1:0] cur_addr = ctl_s2_r[0] ? addr_r : adr_s2_r;

// no command is taken on the rising edge right after a command
always @(posedge clk) begin
    if (reset) begin
        addr_r <= {(`B4S_ADDR_W+2){1'b0}};
        phase_r <= 1'b0;
        rd_pend_r <= 1'b0;
        wr_pend_r <= 1'b0;
        rd_row_r <= {`B4S_ADDR_W{1'b0}};
        wr_row_r <= {`B4S_ADDR_W{1'b0}};
        rd_start_r <= 2'h0;
        wr_start_r <= 2'h0;
    end else begin
        rd_pend_r <= 1'b0;
        wr_pend_r <= 1'b0;
        if (k_rise) begin
            if (phase_r) begin
                phase_r <= 1'b0;
            end else if (!ctl_s2_r[0]) begin
                if (!ctl_s2_r[0]) begin
                    addr_r <= adr_s2_r;
                end
                if (ctl_s2_r[1]) begin
                    rd_pend_r <= 1'b1;
                    rd_row_r <= cur_addr[`B4S_ADDR_W+1:2];
                    rd_start_r <= cur_addr[1:0];
                    phase_r <= 1'b1;
                end else begin
                    wr_pend_r <= 1'b1;
                    wr_row_r <= cur_addr[`B4S_ADDR_W+1:2];
                    wr_start_r <= cur_addr[1:0];
                    phase_r <= 1'b1;
                end
            end
        end
    end
end

// ----------------------------------------------------------------
// write data capture, two-entry write buffer, array
// ----------------------------------------------------------------
reg [`B4S_DATA_W-1:0] mem_r [0:`B4S_WORDS-1];
reg [`B4S_DATA_W-1:0] wbuf_d_r [0:`B4S_BUF_DEPTH-1][0:`B4S_BURST-1];
reg [`B4S_LANES-1:0] wbuf_m_r [0:`B4S_BUF_DEPTH-1][0:`B4S_BURST-1];
reg [`B4S_ADDR_W-1:0] wbuf_row_r [0:`B4S_BUF_DEPTH-1];
reg [`B4S_BUF_DEPTH-1:0] wbuf_v_r;
reg wbuf_head_r; // slot being filled
reg [2:0] wcnt_r; // words still expected, 0 idle
reg wwait_r; // waiting for first data edge
reg [1:0] wstep_r;
reg [`B4S_ADDR_W-1:0] cap_row_r;
reg [1:0] cap_start_r;
integer wi;
integer li;

// commit the older slot when a new write claims it, on the third write
always @(posedge clk) begin
    if (reset) begin
        wbuf_v_r <= {`B4S_BUF_DEPTH{1'b0}};
        wbuf_head_r <= 1'b0;
        wcnt_r <= 3'h0;
        wwait_r <= 1'b0;
        wstep_r <= 2'h0;
        cap_row_r <= {`B4S_ADDR_W{1'b0}};
        cap_start_r <= 2'h0;
    end else begin
        if (wr_pend_r) begin
            wwait_r <= 1'b1;
            cap_row_r <= wr_row_r;
            cap_start_r <= wr_start_r;
            if (wbuf_v_r[~wbuf_head_r]) begin
                for (wi = 0; wi < `B4S_BURST; wi = wi + 1) begin
                    for (li = 0; li < `B4S_LANES; li = li + 1) begin
                        if (wbuf_m_r[~wbuf_head_r][wi][li]) begin
                            mem_r[{wbuf_row_r[~wbuf_head_r], b4s_pos(2'h0, wi[1:0])}]
                                [li*`B4S_LANE_W +: `B4S_LANE_W] <=
                                wbuf_d_r[~wbuf_head_r][wi][li*`B4S_LANE_W +: `B4S_LANE_W];
                        end
                    end
                end
            end
            wbuf_v_r[~wbuf_head_r] <= 1'b0;
        end
        if (wwait_r && k_rise) begin
            wwait_r <= 1'b0;
            wcnt_r <= 3'h3;
            wstep_r <= 2'h1;
            wbuf_head_r <= ~wbuf_head_r;
            wbuf_row_r[~wbuf_head_r] <= cap_row_r;
            wbuf_v_r[~wbuf_head_r] <= 1'b1;
            for (wi = 0; wi < `B4S_BURST; wi = wi + 1) begin
                wbuf_m_r[~wbuf_head_r][wi] <= {`B4S_LANES{1'b0}};
            end
            // first word rides on the same rise that opens the slot
            wbuf_d_r[~wbuf_head_r][cap_start_r] <= d_s2_r;
            wbuf_m_r[~wbuf_head_r][cap_start_r] <= ~bw_s2_r;
        end
        if (wcnt_r != 3'h0 && (k_rise || k_fall)) begin
            wbuf_d_r[wbuf_head_r][b4s_pos(cap_start_r, wstep_r)] <= d_s2_r;
            wbuf_m_r[wbuf_head_r][b4s_pos(cap_start_r, wstep_r)] <= ~bw_s2_r;
            wstep_r <= wstep_r + 2'h1;
            wcnt_r <= wcnt_r - 3'h1;
        end
    end
end
// a read never commits anything, so select high leaves the array alone

// ----------------------------------------------------------------
// read path with coherent merge
// ----------------------------------------------------------------
function [`B4S_DATA_W-1:0] b4s_merge;
    input [`B4S_DATA_W-1:0] base;
    input [`B4S_DATA_W-1:0] nw;
    input [`B4S_LANES-1:0] m;
    integer k;
    begin
        b4s_merge = base;
        for (k = 0; k < `B4S_LANES; k = k + 1) begin
            if (m[k]) begin
                b4s_merge[k*`B4S_LANE_W +: `B4S_LANE_W] = nw[k*`B4S_LANE_W +: `B4S_LANE_W];
            end
        end
    end
endfunction

reg [`B4S_DATA_W-1:0] rd_word [0:`B4S_BURST-1];
reg [2:0] rcnt_r;
reg [1:0] rstep_r;
reg rwait_r;
reg [`B4S_ADDR_W-1:0] rrow_r;
reg [1:0] rstart_r;
reg [`B4S_DATA_W-1:0] rdat_r [0:`B4S_BURST-1];
integer ri;
integer bj;

// older slot first, then newer one so the latest write wins
always @* begin
    for (ri = 0; ri < `B4S_BURST; ri = ri + 1) begin
        rd_word[ri] = mem_r[{rd_row_r, ri[1:0]}];
        for (bj = 0; bj < `B4S_BUF_DEPTH; bj = bj + 1) begin
            if (wbuf_v_r[bj[0] ^ ~wbuf_head_r] &&
                wbuf_row_r[bj[0] ^ ~wbuf_head_r] == rd_row_r) begin
                rd_word[ri] = b4s_merge(rd_word[ri], wbuf_d_r[bj[0] ^ ~wbuf_head_r][ri],
                                        wbuf_m_r[bj[0] ^ ~wbuf_head_r][ri]);
            end
        end
    end
end

// words go out on inverted edge first, true edge second
always @(posedge clk) begin
    if (reset) begin
        rcnt_r <= 3'h0;
        rstep_r <= 2'h0;
        rwait_r <= 1'b0;
        rrow_r <= {`B4S_ADDR_W{1'b0}};
        rstart_r <= 2'h0;
        dq_out <= {`B4S_DATA_W{1'b0}};
        dq_oe <= 1'b0;
    end else begin
        if (rd_pend_r) begin
            rwait_r <= 1'b1;
            rstart_r <= rd_start_r;
            for (ri = 0; ri < `B4S_BURST; ri = ri + 1) begin
                rdat_r[ri] <= rd_word[ri];
            end
        end
        // first inverted edge after the next true rise is t+1.5
        if (rwait_r && k_rise) begin
            rwait_r <= 1'b0;
            rcnt_r <= 3'h4;
            rstep_r <= 2'h0;
        end
        if (rcnt_r != 3'h0 && ((rstep_r[0] == 1'b0 && n_edge) ||
                               (rstep_r[0] == 1'b1 && t_edge))) begin
            dq_out <= rdat_r[b4s_pos(rstart_r, rstep_r)];
            dq_oe <= 1'b1;
            rstep_r <= rstep_r + 2'h1;
            rcnt_r <= rcnt_r - 3'h1;
        end else if (rcnt_r == 3'h0 && (n_edge || t_edge)) begin
            dq_oe <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// echo clocks and loop status
// ----------------------------------------------------------------
reg [10:0] lock_cnt_r;
// echo follows the launching clock edges so it lines up with data
always @(posedge clk) begin
    if (reset) begin
        echo_clock <= 1'b0;
        echo_clock_n <= 1'b1;
        dll_active <= 1'b0;
        dll_locked <= 1'b0;
        lock_cnt_r <= 11'h000;
    end else begin
        if (t_edge) begin
            echo_clock <= 1'b1;
            echo_clock_n <= 1'b0;
        end else if (n_edge) begin
            echo_clock <= 1'b0;
            echo_clock_n <= 1'b1;
        end
        dll_active <= doff_s_r[1];
        if (!doff_s_r[1]) begin
            lock_cnt_r <= 11'h000;
            dll_locked <= 1'b0;
        end else if (k_rise && lock_cnt_r != `B4S_DLL_LOCK_CYC) begin
            lock_cnt_r <= lock_cnt_r + 11'h001;
        end else if (lock_cnt_r == `B4S_DLL_LOCK_CYC) begin
            dll_locked <= 1'b1;
        end
    end
end

endmodule // b4s_core

//--- b4s_props.sv
// property checker for the burst-of-four sram port
`include "b4sram_defines.vh"
module b4s_props (
    // system
    input wire logic clk,
    input wire logic reset,
    // link clocks and loop control
    input wire logic in_clk,
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic dll_enable_n_low,
    // outputs under watch
    input wire logic [`B4S_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic dll_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire single_mode = out_clk & out_clk_n;
    logic [3:0] launch_r;
    // launches while driving; a lone burst must close on a multiple of four
    always @(posedge clk) begin
        if (reset || !dq_oe) launch_r <= 4'h0;
        else launch_r <= launch_r + {3'h0, $changed(echo_clock)};
    end
    property p_idle; disable iff (1'b0) reset |=> !dq_oe && echo_clock_n; endproperty
    a_idle: assert property (p_idle) else $error("bus driven after reset");
    property p_pair; echo_clock_n != echo_clock; endproperty
    a_pair: assert property (p_pair) else $error("echo pair not complementary");
    property p_free; single_mode && $rose(in_clk) |-> ##[1:8] $changed(echo_clock); endproperty
    a_free: assert property (p_free) else $error("echo clock stalled");
    property p_single; single_mode && $changed(echo_clock) |-> echo_clock == in_clk; endproperty
    a_single: assert property (p_single) else $error("echo off input clock");
    property p_sep; !single_mode && $changed(echo_clock) |-> echo_clock == out_clk; endproperty
    a_sep: assert property (p_sep) else $error("echo off output clock");
    property p_hold; $past(dq_oe) && dq_oe && $stable(echo_clock) |-> $stable(dq_out); endproperty
    a_hold: assert property (p_hold) else $error("data moved between launches");
    property p_burst; $fell(dq_oe) |-> launch_r[1:0] == 2'h0 && launch_r != 4'h0; endproperty
    a_burst: assert property (p_burst) else $error("burst not four words");
    property p_dll_on; $rose(dll_enable_n_low) |-> ##[1:4] dll_active; endproperty
    a_dll_on: assert property (p_dll_on) else $error("loop not enabled");
    property p_dll_off; $fell(dll_enable_n_low) |-> ##[1:4] !dll_active; endproperty
    a_dll_off: assert property (p_dll_off) else $error("loop not disabled");
    c_read: cover property ($rose(dq_oe) && single_mode);
    c_sep: cover property ($rose(dq_oe) && !single_mode);
    c_end: cover property ($fell(dq_oe));
endmodule // b4s_props

bind b4s_core b4s_props u_props (.clk(clk), .reset(reset), .in_clk(in_clk),
    .out_clk(out_clk), .out_clk_n(out_clk_n), .dll_enable_n_low(dll_enable_n_low),
    .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .dll_active(dll_active));

//--- b4s_ctrl_model.sv
// far-side controller model: link clocks and shared-bus driver
module b4s_ctrl_model (
    // control from the bench
    input wire logic sep_mode,
    input wire logic drive_en,
    input wire logic [35:0] wdata,
    // link side
    output logic in_clk,
    output logic out_clk,
    output logic out_clk_n,
    output logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic dly = 1'b0;
    logic [35:0] last_r = 36'h0;
    // input clock runs free at the link rate
    initial in_clk = 1'b0;
    always #80 in_clk = ~in_clk;
    // output pair trails slightly; both held high selects single-clock mode
    always @(in_clk) dly <= #16 in_clk;
    assign out_clk = sep_mode ? dly : 1'b1;
    assign out_clk_n = sep_mode ? ~dly : 1'b1;
    // released bus shows the inverse, so a stale word never passes as data
    always @(in_clk) if (drive_en) last_r <= wdata;
    assign dq_in = drive_en ? wdata : ~last_r;
endmodule // b4s_ctrl_model

//--- test_burst4_common_io_sram.sv
// self-checking bench for the burst-of-four sram port
module test_burst4_common_io_sram;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, rw = 1'b1, ld_n = 1'b1, dll_n = 1'b1, sep = 1'b0;
    logic den = 1'b0, in_clk, out_clk, out_clk_n, dq_oe, ec, ec_n, dll_act, dll_lk;
    logic [7:0] row = 8'h00;
    logic [1:0] st = 2'h0;
    logic [3:0] ben_n = 4'hf;
    logic [35:0] wd = 36'h0, dq_in, dq_out, mem [0:1023];
    int bad_count = 0, n_checks = 0;
    always #4 clk = ~clk;
    b4s_ctrl_model far (.sep_mode(sep), .drive_en(den), .wdata(wd), .in_clk(in_clk),
        .out_clk(out_clk), .out_clk_n(out_clk_n), .dq_in(dq_in));
    b4s_core dut (.clk(clk), .reset(reset), .in_clk(in_clk), .out_clk(out_clk),
        .out_clk_n(out_clk_n), .read_write_sel(rw), .address_load_n(ld_n),
        .array_address(row), .burst_start_bit_low(st[0]), .burst_start_bit_high(st[1]),
        .byte_write_enable_n(ben_n), .dll_enable_n_low(dll_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(ec), .echo_clock_n(ec_n),
        .dll_active(dll_act), .dll_locked(dll_lk));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // mid of next half period, clear of the design's sampling lag
    task half;
        logic v;
        int n;
        v = in_clk;
        n = 0;
        while (in_clk === v) begin
            @(posedge clk);
            n++;
            if (n > 40) begin
                bad_count++;
                give_verdict();
            end
        end
        repeat (5) @(posedge clk);
    endtask
    // command on an even rise; every burst spans two periods
    task cmd(input logic r, input logic [7:0] a, input logic [1:0] s);
        if (in_clk) half();
        rw <= r;
        ld_n <= 1'b0;
        row <= a;
        st <= s;
        half();
        ld_n <= 1'b1;
    endtask
    task wr(input logic [7:0] a, input logic [1:0] s, input logic [35:0] b,
            input logic [3:0] m);
        logic [35:0] w;
        cmd(1'b0, a, s);
        half();
        den <= 1'b1;
        ben_n <= m;
        for (int k = 0; k < 4; k++) begin
            w = b + 36'(k);
            wd <= w;
            for (int l = 0; l < 4; l++)
                if (!m[l]) mem[{a, s + 2'(k)}][9*l +: 9] = w[9*l +: 9];
            half();
        end
        den <= 1'b0;
        half();
    endtask
    // nop cycles follow the command; the burst must still finish
    task rd(input logic [7:0] a, input logic [1:0] s);
        cmd(1'b1, a, s);
        repeat (2) half();
        for (int k = 0; k < 4; k++) begin
            half();
            check(dq_out, mem[{a, s + 2'(k)}]);
            check(36'(dq_oe), 36'h1);
        end
        half();
        check(36'(dq_oe), 36'h0);
    endtask
    task dll_test;
        dll_n <= 1'b0;
        repeat (6) @(posedge clk);
        check(36'(dll_act), 36'h0);
        dll_n <= 1'b1;
        repeat (6) @(posedge clk);
        check(36'(dll_act), 36'h1);
        check(36'(dll_lk), 36'h0);
    endtask
    // main sequence: buffer hits, masked merge, array reads, separate clocks
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        half();
        dll_test();
        wr(8'h12, 2'h0, 36'h1_0203_0400, 4'h0);
        rd(8'h12, 2'h0);
        wr(8'h12, 2'h2, 36'h8_8888_8800, 4'ha);
        rd(8'h12, 2'h2);
        wr(8'h34, 2'h1, 36'h5_5555_5550, 4'h0);
        wr(8'h56, 2'h3, 36'h3_3333_3330, 4'h0);
        rd(8'h12, 2'h1);
        sep <= 1'b1;
        rd(8'h34, 2'h1);
        rd(8'h56, 2'h3);
        repeat (2) half();
        give_verdict();
    end
endmodule // test_burst4_common_io_sram
